// file: rtl/sefe_map.svh
// Purpose: Constants of the serial EEPROM front end (both ends)
// Assumes: 200 MHz system clock, 160 ns serial clock period in the bench
// Notes:   Cycle counts are derived from times, never typed in directly
`ifndef SEFE_MAP_SVH
`define SEFE_MAP_SVH
`define SEFE_CLK_PERIOD_NS  5
`define SEFE_SCK_PERIOD_NS  160
`define SEFE_HALF_CYC       ((`SEFE_SCK_PERIOD_NS / 2) / `SEFE_CLK_PERIOD_NS)
`define SEFE_BYTE_BITS      8
`define SEFE_MEM_WORDS      1024
`define SEFE_ID_PAGE_BYTES  32
`define SEFE_FIFO_DEPTH     8
`define SEFE_PROT_RST       2'h0
`define SEFE_PROT_NONE_BASE 11'h400
`define SEFE_PROT_QTR_BASE  11'h300
`define SEFE_PROT_HALF_BASE 11'h200
`define SEFE_PROT_ALL_BASE  11'h000
`define SEFE_IDLE_PIN       1'h1
`endif

// file: rtl/sefe_pkg.sv
// Purpose: Types shared by both ends of the serial EEPROM front end
// Assumes: Constants come from sefe_map.svh
// Notes:   One-hot state codes written out
package sefe_pkg;
    typedef enum logic [4:0] {
        SEFE_H_IDLE = 5'h01,
        SEFE_H_SEL  = 5'h02,
        SEFE_H_LO   = 5'h04,
        SEFE_H_HI   = 5'h08,
        SEFE_H_END  = 5'h10
    } sefe_host_state_t;
    typedef logic [7:0] sefe_byte_t;
endpackage

// file: rtl/sefe_if.sv
// Purpose: Serial pins between bus master and EEPROM front end
// Assumes: Data out line pulled high when nobody drives it
// Notes:   Wire level of the shared data out line is resolved here
`timescale 1ns/1ps
interface sefe_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic hold_n;
    logic wp_n;
    logic miso_o;
    logic miso_oe;
    logic miso;
    // Pull-up stands in for the released line
    assign miso = miso_oe ? miso_o : 1'h1;
    modport dev  (input sclk, cs_n, mosi, hold_n, wp_n, output miso_o, miso_oe);
    modport host (output sclk, cs_n, mosi, hold_n, wp_n, input miso);
endinterface

// file: rtl/sefe_dev.sv
// Purpose: Device end: serial front end of a 1024 x 8 SPI EEPROM
// Assumes: All pins asynchronous to clk, synchronised by two flops
// Notes:   Received bytes queue in an 8-word FIFO toward the core
`timescale 1ns/1ps
`include "sefe_map.svh"

module sefe_dev
    import sefe_pkg::*;
#(
    parameter int DEPTH   = `SEFE_FIFO_DEPTH,
    parameter bit HAS_ID  = 1'h1
) (
    input  wire logic        clk,
    input  wire logic        reset,
    sefe_if.dev              link,
    output sefe_byte_t       rx_data,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    output logic             rx_room,
    output logic             rx_overrun,
    input  wire sefe_byte_t  tx_data,
    input  wire logic        tx_valid,
    output logic             tx_taken,
    input  wire logic        write_busy,
    input  wire logic        prot_wr,
    input  wire logic [1:0]  prot_val,
    output logic             protect_range_hi_bit,
    output logic             protect_range_lo_bit,
    output logic [10:0]      protect_base,
    input  wire logic        id_lock,
    output logic             id_locked,
    output logic             selected,
    output logic             standby,
    output logic             paused,
    output logic             armed,
    output logic             wp_level
);
    // Pin order in the sync vectors: sclk, cs_n, mosi, hold_n, wp_n
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync3;
    logic       sck;
    logic       csn;
    logic       hldn;
    logic       sck_rise;
    logic       sck_fall;
    logic       active;
    logic       run;
    logic [2:0] bit_cnt;
    logic       byte_seen;
    logic       tx_on;
    sefe_byte_t sr_in;
    sefe_byte_t sr_out;
    sefe_byte_t push_data;
    logic       push;
    logic       fifo_in_ready;

    // First address of the protected area; array ends at 1024
    function automatic logic [10:0] prot_base_of(input logic [1:0] r);
        unique case (r)
            2'h0: prot_base_of = `SEFE_PROT_NONE_BASE;
            2'h1: prot_base_of = `SEFE_PROT_QTR_BASE;
            2'h2: prot_base_of = `SEFE_PROT_HALF_BASE;
            2'h3: prot_base_of = `SEFE_PROT_ALL_BASE;
        endcase
    endfunction

    // Two flops per pin, third stage only for edge finding
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1 <= 5'h1b;
            sync2 <= 5'h1b;
            sync3 <= 5'h1b;
        end else begin
            sync1 <= {link.sclk, link.cs_n, link.mosi, link.hold_n, link.wp_n};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign sck      = sync2[4];
    assign csn      = sync2[3];
    assign hldn     = sync2[1];
    assign sck_rise = sck & ~sync3[4];
    assign sck_fall = ~sck & sync3[4];
    assign active   = armed & ~csn;
    // Same edge rule in both clock modes, idle level irrelevant
    assign run      = active & ~paused;

    // Deaf after reset until select falls from high
    always_ff @(posedge clk) begin
        if (reset) begin
            armed <= 1'h0;
        end else if (~csn & sync3[3]) begin
            armed <= 1'h1;
        end
    end

    // Pause on hold low with clock low, leave on release with clock low
    always_ff @(posedge clk) begin
        if (reset || csn) begin
            paused <= 1'h0; // Deselect clears a pause as well
        end else if (!paused && active && !hldn && sync3[1] && !sck) begin
            paused <= 1'h1;
        end else if (paused && hldn && !sck) begin
            paused <= 1'h0; // Resumes at the held bit count
        end
    end

    // Input shifter; a pause freezes count and data
    always_ff @(posedge clk) begin
        if (reset || csn) begin
            bit_cnt   <= 3'h0; // Next transaction starts at bit count 0
            byte_seen <= 1'h0;
            sr_in     <= 8'h00;
            push      <= 1'h0;
        end else begin
            push <= 1'h0;
            if (run && sck_rise) begin
                sr_in   <= {sr_in[6:0], sync2[2]}; // MSB arrives first
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    push      <= 1'h1;
                    push_data <= {sr_in[6:0], sync2[2]};
                    byte_seen <= 1'h1;
                end
            end
        end
    end

    // Output shifter loads at each byte boundary after the first byte
    always_ff @(posedge clk) begin
        if (reset || csn) begin
            sr_out   <= 8'h00;
            tx_on    <= 1'h0;
            tx_taken <= 1'h0;
        end else begin
            tx_taken <= 1'h0;
            if (run && sck_fall) begin
                if (bit_cnt == 3'h0 && byte_seen) begin
                    tx_on <= tx_valid; // First bit right after instruction
                    if (tx_valid) begin
                        sr_out   <= tx_data;
                        tx_taken <= 1'h1;
                    end
                end else begin
                    sr_out <= {sr_out[6:0], 1'h0}; // MSB leaves first
                end
            end
        end
    end

    assign link.miso_o = sr_out[7];

    // Drive only while selected, unpaused and sending
    always_ff @(posedge clk) begin
        if (reset) begin
            link.miso_oe <= 1'h0;
        end else begin
            link.miso_oe <= run & tx_on & ~(~sck & sync3[4] & bit_cnt == 3'h0 & ~tx_valid);
        end
    end

    // Power state follows select and the write cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            selected <= 1'h0;
            standby  <= 1'h1;
            wp_level <= 1'h1;
        end else begin
            selected <= active;
            standby  <= ~active & ~write_busy;
            wp_level <= sync2[0];
        end
    end

    // Protect range only changes while the protect pin is high
    always_ff @(posedge clk) begin
        if (reset) begin
            {protect_range_hi_bit, protect_range_lo_bit} <= `SEFE_PROT_RST;
            protect_base <= prot_base_of(`SEFE_PROT_RST);
        end else if (prot_wr && sync2[0]) begin
            {protect_range_hi_bit, protect_range_lo_bit} <= prot_val;
            protect_base <= prot_base_of(prot_val); // Bounds in 1024 words
        end
    end

    // Identification page lock is one-way
    always_ff @(posedge clk) begin
        if (reset) begin
            id_locked <= 1'h0;
        end else if (HAS_ID && id_lock) begin
            id_locked <= 1'h1;
        end
    end

    // Overrun is sticky until the next select; a drop beats the clear
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_overrun <= 1'h0;
            rx_room    <= 1'h1;
        end else begin
            rx_room <= fifo_in_ready;
            if (push && !fifo_in_ready) begin
                rx_overrun <= 1'h1;
            end else if (~csn & sync3[3]) begin
                rx_overrun <= 1'h0;
            end
        end
    end

    // The serial link cannot stall, so a full queue drops and flags
    sefe_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_data   (push_data),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .out_data  (rx_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );
endmodule

// file: rtl/sefe_host.sv
// Purpose: Master end: drives the serial EEPROM pins byte by byte
// Assumes: Serial clock made here by dividing clk
// Notes:   Clock may stretch high between bytes; also holds the shared FIFO
`timescale 1ns/1ps
`include "sefe_map.svh"

// Plain synchronous FIFO, registered flags
module sefe_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `SEFE_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign push = in_valid & in_ready;
    assign pop  = out_valid & out_ready;
    assign out_data = mem[rd_ptr];

    // Storage needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'h1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'h1;
            end
        end
    end

    // Count and flags move together
    always_ff @(posedge clk) begin
        if (reset) begin
            count     <= '0;
            in_ready  <= 1'h1;
            out_valid <= 1'h0;
        end else begin
            count     <= count + (AW+1)'(push) - (AW+1)'(pop);
            in_ready  <= (count + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
            out_valid <= (count + (AW+1)'(push) - (AW+1)'(pop)) != '0;
        end
    end
endmodule

module sefe_host
    import sefe_pkg::*;
#(
    parameter int HALF = `SEFE_HALF_CYC
) (
    input  wire logic       clk,
    input  wire logic       reset,
    sefe_if.host            link,
    input  wire logic       cpol,
    input  wire sefe_byte_t cmd_data,
    input  wire logic       cmd_last,
    input  wire logic       cmd_valid,
    output logic            cmd_ready,
    output sefe_byte_t      resp_data,
    output logic            resp_valid,
    input  wire logic       pause_req,
    input  wire logic       wp_protect
);
    sefe_host_state_t state;
    logic [7:0]       timer;
    logic [2:0]       bit_cnt;
    sefe_byte_t       sh_tx;
    sefe_byte_t       sh_rx;
    logic             last;
    logic [1:0]       miso_sync;
    logic             half_done;
    logic             held;

    assign half_done = (timer == 8'(HALF - 1));

    // Data out of the device is asynchronous here
    always_ff @(posedge clk) begin
        if (reset) begin
            miso_sync <= 2'h3;
        end else begin
            miso_sync <= {miso_sync[0], link.miso};
        end
    end

    // Write-protect only moves with select high
    always_ff @(posedge clk) begin
        if (reset) begin
            link.wp_n <= `SEFE_IDLE_PIN;
        end else if (state == SEFE_H_IDLE) begin
            link.wp_n <= ~wp_protect;
        end
    end

    // Hold only with select low and clock low
    always_ff @(posedge clk) begin
        if (reset) begin
            link.hold_n <= `SEFE_IDLE_PIN;
        end else if (state == SEFE_H_LO) begin
            link.hold_n <= ~pause_req;
        end else begin
            link.hold_n <= `SEFE_IDLE_PIN;
        end
    end

    // Bit sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state      <= SEFE_H_IDLE;
            timer      <= 8'h00;
            bit_cnt    <= 3'h0;
            sh_tx      <= 8'h00;
            sh_rx      <= 8'h00;
            last       <= 1'h0;
            held       <= 1'h0;
            cmd_ready  <= 1'h0;
            resp_valid <= 1'h0;
            resp_data  <= 8'h00;
            link.sclk  <= 1'h0;
            link.cs_n  <= `SEFE_IDLE_PIN; // High before first select
            link.mosi  <= 1'h0;
        end else begin
            cmd_ready  <= 1'h0;
            resp_valid <= 1'h0;
            timer      <= half_done ? 8'h00 : timer + 8'h01;
            unique case (state)
                SEFE_H_IDLE: begin
                    link.sclk <= cpol; // Idle level per mode
                    timer     <= 8'h00;
                    if (cmd_valid && !cmd_ready) begin
                        sh_tx     <= cmd_data;
                        last      <= cmd_last;
                        cmd_ready <= 1'h1;
                        link.cs_n <= 1'h0;
                        state     <= SEFE_H_SEL;
                    end
                end
                SEFE_H_SEL: begin
                    if (half_done) begin
                        link.sclk <= 1'h0;
                        link.mosi <= sh_tx[7]; // MSB first
                        state     <= SEFE_H_LO;
                    end
                end
                SEFE_H_LO: begin
                    if (pause_req || !link.hold_n) begin
                        timer <= timer; // Position kept while paused
                    end else if (half_done) begin
                        link.sclk <= 1'h1; // Device samples here
                        state     <= SEFE_H_HI;
                    end
                end
                SEFE_H_HI: begin
                    if (half_done) begin
                        timer <= half_done ? 8'h00 : timer;
                        sh_rx <= {sh_rx[6:0], miso_sync[1]};
                        sh_tx <= {sh_tx[6:0], 1'h0};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt != 3'h7) begin
                            link.sclk <= 1'h0;
                            link.mosi <= sh_tx[6];
                            state     <= SEFE_H_LO;
                        end else begin
                            // A stretched byte answers once, not every cycle
                            if (!held) begin
                                resp_data  <= {sh_rx[6:0], miso_sync[1]};
                                resp_valid <= 1'h1;
                            end
                            held <= 1'h0;
                            if (last) begin
                                link.sclk <= cpol;
                                state     <= SEFE_H_END;
                            end else if (cmd_valid) begin
                                sh_tx     <= cmd_data;
                                last      <= cmd_last;
                                cmd_ready <= 1'h1;
                                link.sclk <= 1'h0;
                                link.mosi <= cmd_data[7];
                                state     <= SEFE_H_LO;
                            end else begin
                                bit_cnt <= bit_cnt; // Stretch high for next byte
                                held    <= 1'h1;
                                timer   <= 8'(HALF - 1);
                                sh_tx   <= sh_tx;
                                sh_rx   <= sh_rx;
                            end
                        end
                    end
                end
                SEFE_H_END: begin
                    if (half_done) begin
                        link.cs_n <= 1'h1;
                        bit_cnt   <= 3'h0;
                        state     <= SEFE_H_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// file: testbench/sefe_link_props.sv
// Purpose: Timing checks on the pins joining master and EEPROM front end
// Assumes: Pins pass two sync flops in the device, serial half period 16 clk
// Notes:   Delays leave room for the device's sync and edge-detect latency
`timescale 1ns/1ps
module sefe_link_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic miso_o,
    input wire logic miso_oe
);
    // All checks live in the system clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_desel_release: assert property (cs_n [*6] |-> !miso_oe)
        else $error("data out driven while deselected");
    a_pause_release: assert property ((!hold_n && !cs_n) [*6] |-> !miso_oe)
        else $error("data out driven during pause");
    a_first_out_low: assert property ($rose(miso_oe) |-> !sclk && !cs_n)
        else $error("data out enabled outside a low clock phase");
    // Shift must follow a fall: clock low now, high eight cycles back
    a_out_on_fall: assert property (miso_oe && $past(miso_oe) && $changed(miso_o)
        |-> !sclk && $past(sclk, 8))
        else $error("data out changed away from a falling clock edge");
    a_mosi_at_rise: assert property ($rose(sclk) && !cs_n
        |-> $stable(mosi) ##1 $stable(mosi))
        else $error("data in moved at a rising clock edge");
    a_wp_in_frame: assert property (!cs_n && !$past(cs_n) |-> $stable(wp_n))
        else $error("write protect changed inside a frame");
    a_pause_start: assert property ($fell(hold_n) |-> !sclk && !cs_n)
        else $error("pause entered with clock high or deselected");
    a_pause_end: assert property ($rose(hold_n) |-> !sclk)
        else $error("pause left with clock high");
endmodule

// file: testbench/tb_spi_eeprom_serial_front_end.sv
// Purpose: Self-checking bench, master end talking to device end
// Assumes: Inputs driven on falling clk edges, seed fixed
// Notes:   Response byte 0 reads pull-up level, device has nothing yet
`timescale 1ns/1ps
module tb_spi_eeprom_serial_front_end
    import sefe_pkg::*;
;
    localparam int LIMIT = 30000;
    logic       clk = 1'h0, reset = 1'h1, cpol = 1'h0;
    logic       cmd_last = 1'h0, cmd_valid = 1'h0, pause_req = 1'h0;
    logic       wp_protect = 1'h0, rx_ready = 1'h0, tx_valid = 1'h0;
    logic       write_busy = 1'h0, prot_wr = 1'h0, id_lock = 1'h0, drain = 1'h1;
    logic [1:0] prot_val = 2'h0;
    sefe_byte_t cmd_data = 8'h00, tx_data = 8'h00, rx_data, resp_data;
    logic       rx_valid, rx_room, rx_overrun, cmd_ready, resp_valid, prh, prl;
    logic       id_locked, selected, standby, paused, armed, wp_level, tx_taken;
    logic [10:0] protect_base;
    sefe_byte_t q_tx[$], q_rx[$], q_rsp[$];
    int         seed = 34496, n_mismatch = 0, checks = 0, cycles = 0, n_taken = 0;

    sefe_if link ();
    sefe_dev i_sefe_dev (.clk(clk), .reset(reset), .link(link), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_room(rx_room),
        .rx_overrun(rx_overrun), .tx_data(tx_data), .tx_valid(tx_valid), .tx_taken(tx_taken),
        .write_busy(write_busy), .prot_wr(prot_wr), .prot_val(prot_val),
        .protect_range_hi_bit(prh), .protect_range_lo_bit(prl),
        .protect_base(protect_base), .id_lock(id_lock), .id_locked(id_locked),
        .selected(selected), .standby(standby), .paused(paused), .armed(armed),
        .wp_level(wp_level));
    sefe_host i_sefe_host (.clk(clk), .reset(reset), .link(link), .cpol(cpol),
        .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .resp_data(resp_data), .resp_valid(resp_valid),
        .pause_req(pause_req), .wp_protect(wp_protect));
    sefe_link_props i_props (.clk(clk), .reset(reset), .sclk(link.sclk),
        .cs_n(link.cs_n), .mosi(link.mosi), .hold_n(link.hold_n), .wp_n(link.wp_n),
        .miso_o(link.miso_o), .miso_oe(link.miso_oe));

    always #2.5 clk = ~clk;
    // Collect received and returned bytes; random stalls on the core side
    always @(posedge clk) begin
        if (rx_valid && rx_ready) q_rx.push_back(rx_data);
        if (resp_valid) q_rsp.push_back(resp_data);
        if (tx_taken) n_taken++;
    end
    always @(negedge clk) rx_ready <= drain & 1'($random(seed));
    // Watchdog cuts a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic summarize();
        if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // First protected address for each range code
    function automatic logic [10:0] base_of(input logic [1:0] p);
        return (p == 2'h0) ? 11'h400 : (p == 2'h1) ? 11'h300 : (p == 2'h2) ? 11'h200 : 11'h000;
    endfunction

    // Released line reads as the pull-up level
    function automatic sefe_byte_t rsp_of(input int i, input logic v, input sefe_byte_t d);
        return (i == 0 || !v) ? 8'hff : d;
    endfunction

    task automatic ticks(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic do_reset(input logic mode);
        reset = 1'h1;
        cpol = mode;
        ticks(16);
        reset = 1'h0;
        ticks(6);
        chk(link.sclk, mode);
        chk(armed, 1'h0);
    endtask

    // One frame of n random bytes, optional pause in byte 2
    task automatic frame(input int n, input bit pz);
        sefe_byte_t b;
        q_tx.delete();
        q_rx.delete();
        q_rsp.delete();
        tx_data = 8'($random(seed));
        n_taken = 0;
        for (int i = 0; i < n; i++) begin
            b = 8'($random(seed));
            q_tx.push_back(b);
            if (i == 3 && pz) ticks(400); // Late byte makes the master stretch
            cmd_data = b;
            cmd_last = (i == n - 1);
            cmd_valid = 1'h1;
            @(negedge clk);
            while (!cmd_ready) @(negedge clk);
            cmd_valid = 1'h0;
            if (i == 1) chk({selected, standby}, 2'h2);
            if (i == 2 && pz) begin
                pause_req = 1'h1;
                ticks(60);
                chk({paused, link.miso}, 2'h3);
                pause_req = 1'h0;
            end
            @(negedge clk);
        end
        while (q_rsp.size() < n || !link.cs_n) @(negedge clk);
        for (int i = 0; i < n; i++) chk(q_rsp[i], rsp_of(i, tx_valid, tx_data));
        chk(16'(q_rsp.size()), 16'(n));
        // One load per byte boundary; mode zero adds the closing fall
        chk(16'(n_taken), !tx_valid ? 16'h0 : 16'(cpol ? n - 1 : n));
    endtask

    // Device must hand on what was shifted in, in order
    task automatic check_rx(input int n);
        while (q_rx.size() < n) @(negedge clk);
        for (int i = 0; i < n; i++) chk(q_rx[i], q_tx[i]);
    endtask

    initial begin
        do_reset(1'h0);
        chk({standby, link.miso, protect_base}, {2'h3, 11'h400});
        // Every range code, then a refused change under write protect
        for (int p = 0; p < 4; p++) begin
            prot_val = 2'(p);
            prot_wr = 1'h1;
            ticks(1);
            prot_wr = 1'h0;
            ticks(3);
            chk({prh, prl, protect_base}, {2'(p), base_of(2'(p))});
        end
        wp_protect = 1'h1;
        ticks(8);
        chk(wp_level, 1'h0);
        prot_val = 2'h1;
        prot_wr = 1'h1;
        ticks(1);
        prot_wr = 1'h0;
        ticks(3);
        chk(protect_base, base_of(2'h3));
        wp_protect = 1'h0;
        write_busy = 1'h1;
        ticks(4);
        chk(standby, 1'h0);
        write_busy = 1'h0;
        id_lock = 1'h1;
        ticks(1);
        id_lock = 1'h0;
        ticks(3);
        chk(id_locked, 1'h1);
        tx_valid = 1'h1;
        frame(5, 1'b0);
        chk(armed, 1'h1);
        check_rx(5);
        frame(6, 1'b1);
        check_rx(6);
        // Fill the FIFO past its depth while the core stalls
        drain = 1'h0;
        tx_valid = 1'h0;
        frame(10, 1'b0);
        chk({rx_room, rx_overrun}, 2'h1);
        drain = 1'h1;
        check_rx(8);
        ticks(20);
        chk(rx_valid, 1'h0);
        tx_valid = 1'h1;
        frame(3, 1'b0);
        chk(rx_overrun, 1'h0);
        check_rx(3);
        do_reset(1'h1);
        frame(4, 1'b1);
        check_rx(4);
        summarize();
    end
endmodule
